// [rtl/scm_consts.svh]
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_CLK_HZ 20000000
`define SCM_RECONF_MS 100
`define SCM_INIT_CYCLES 16
`define SCM_CFG_WORDS 64
`define SCM_FIFO_DEPTH 4
`define SCM_SCHEME_MEM 2'h0
`define SCM_SCHEME_SER 2'h1
`define SCM_SCHEME_ASYNC 2'h2
`endif

// [rtl/scm_pkg.sv]
package scm_pkg;
    typedef enum logic [1:0] {SCM_MEM, SCM_SER, SCM_ASYNC, SCM_BAD} scm_scheme_e;
    typedef enum {SCM_IDLE, SCM_LOAD, SCM_INIT, SCM_USER} scm_state_e;
endpackage

// [rtl/scm_fifo.sv]
`timescale 1ns/1ps
module scm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("scm_fifo depth must be a power of two of at least two");
    end

    assign in_ready = cnt != (AW+1)'(DEPTH);
    assign out_valid = cnt != '0;
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wp] <= in_data;
    end

    a_fifo_count: assert property (@(posedge clock) disable iff (!nrst)
        cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// [rtl/scm_top.sv]
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_top #(
    parameter int WIDTH = 8,
    parameter int CFG_WORDS = `SCM_CFG_WORDS,
    parameter int INIT_CYCLES = `SCM_INIT_CYCLES,
    parameter int RECONF_LIMIT = (`SCM_CLK_HZ / 1000) * `SCM_RECONF_MS,
    parameter int USER_PINS = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] scheme_sel,
    input wire logic reconfig_n,
    input wire logic chain_config_enable_in_n,
    input wire logic cfg_valid,
    output logic cfg_ready,
    input wire logic [WIDTH-1:0] cfg_data,
    output logic chain_config_enable_out_n,
    output logic user_mode,
    output logic init_active,
    output logic reg_reset,
    output logic scheme_error,
    output logic reconf_timeout,
    output logic [USER_PINS-1:0] io_oe,
    output logic [WIDTH-1:0] cfg_checksum
);
    import scm_pkg::*;

    initial
    begin
        if (CFG_WORDS < 1 || INIT_CYCLES < 1 || RECONF_LIMIT < 1 || WIDTH < 1)
            $error("scm_top parameters out of range");
    end

    // Pins and the other chain device are asynchronous to clock.
    logic [2:0] sync1, sync2;
    logic [1:0] sch1, sch2;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sch1 <= 2'h0;
            sch2 <= 2'h0;
        end
        else
        begin
            sync1 <= {reconfig_n, chain_config_enable_in_n, 1'b1};
            sync2 <= sync1;
            sch1 <= scheme_sel;
            sch2 <= sch1;
        end
    end
    logic reconf_req, chain_en;
    assign reconf_req = !sync2[2];
    assign chain_en = !sync2[1];

    logic f_valid, f_ready, f_in_ready;
    logic [WIDTH-1:0] f_data;
    scm_state_e state, next_state;

    scm_fifo #(.WIDTH(WIDTH), .DEPTH(`SCM_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(cfg_valid && state == SCM_LOAD),
        .in_ready(f_in_ready),
        .in_data(cfg_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    logic [31:0] words, next_words, init_cnt, next_init_cnt, rc_cnt, next_rc_cnt;
    logic rc_active, next_rc_active;
    logic [1:0] scheme, next_scheme;
    logic next_cfg_ready, next_ceo_n, next_user, next_init, next_rst, next_err, next_tmo;
    logic [USER_PINS-1:0] next_oe;
    logic [WIDTH-1:0] next_sum;
    logic scheme_ok;

    // A scheme is latched at the start of each load and held through it.
    assign scheme_ok = sch2 == `SCM_SCHEME_MEM || sch2 == `SCM_SCHEME_SER
                       || sch2 == `SCM_SCHEME_ASYNC;
    assign f_ready = state == SCM_LOAD;

    always_comb
    begin
        next_state = state;
        next_words = words;
        next_init_cnt = init_cnt;
        next_scheme = scheme;
        next_sum = cfg_checksum;
        next_err = scheme_error;
        next_rc_active = rc_active;
        next_rc_cnt = rc_cnt;
        next_tmo = reconf_timeout;
        case (state)
            SCM_IDLE:
            begin
                // Waiting for enable lets an external source start the load unaided.
                if (chain_en && !reconf_req)
                begin
                    if (scheme_ok)
                    begin
                        next_state = SCM_LOAD;
                        next_scheme = sch2;
                        next_words = '0;
                        next_sum = '0;
                        next_err = 1'b0;
                    end
                    else
                        next_err = 1'b1;
                end
            end
            SCM_LOAD:
            begin
                if (reconf_req || !chain_en)
                    next_state = SCM_IDLE;
                else if (f_valid)
                begin
                    next_sum = cfg_checksum ^ f_data;
                    next_words = words + 32'h1;
                    if (words == 32'(CFG_WORDS - 1))
                    begin
                        next_state = SCM_INIT;
                        next_init_cnt = '0;
                    end
                end
            end
            SCM_INIT:
            begin
                if (reconf_req)
                    next_state = SCM_IDLE;
                else if (init_cnt == 32'(INIT_CYCLES - 1))
                    next_state = SCM_USER;
                else
                    next_init_cnt = init_cnt + 32'h1;
            end
            SCM_USER:
            begin
                if (reconf_req)
                begin
                    next_state = SCM_IDLE;
                    next_rc_active = 1'b1;
                    next_rc_cnt = '0;
                    next_tmo = 1'b0;
                end
            end
            default: next_state = SCM_IDLE;
        endcase
        // Count the reconfiguration from forcing command mode to user mode.
        if (rc_active)
        begin
            if (next_state == SCM_USER)
                next_rc_active = 1'b0;
            else if (rc_cnt == 32'(RECONF_LIMIT - 1))
            begin
                next_tmo = 1'b1;
                next_rc_active = 1'b0;
            end
            else
                next_rc_cnt = rc_cnt + 32'h1;
        end
        next_cfg_ready = next_state == SCM_LOAD && f_in_ready;
        next_user = next_state == SCM_USER;
        next_init = next_state == SCM_INIT;
        next_rst = next_state != SCM_USER;
        next_oe = next_state == SCM_USER ? '1 : '0;
        next_ceo_n = !(next_state == SCM_INIT || next_state == SCM_USER);
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= SCM_IDLE;
            words <= '0;
            init_cnt <= '0;
            scheme <= `SCM_SCHEME_MEM;
            cfg_checksum <= '0;
            scheme_error <= 1'b0;
            rc_active <= 1'b0;
            rc_cnt <= '0;
            reconf_timeout <= 1'b0;
            cfg_ready <= 1'b0;
            user_mode <= 1'b0;
            init_active <= 1'b0;
            reg_reset <= 1'b1;
            io_oe <= '0;
            chain_config_enable_out_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            words <= next_words;
            init_cnt <= next_init_cnt;
            scheme <= next_scheme;
            cfg_checksum <= next_sum;
            scheme_error <= next_err;
            rc_active <= next_rc_active;
            rc_cnt <= next_rc_cnt;
            reconf_timeout <= next_tmo;
            cfg_ready <= next_cfg_ready;
            user_mode <= next_user;
            init_active <= next_init;
            reg_reset <= next_rst;
            io_oe <= next_oe;
            chain_config_enable_out_n <= next_ceo_n;
        end
    end

    sequence s_init_run;
        init_active [*2];
    endsequence

    a_pins_hiz: assert property (@(posedge clock) disable iff (!nrst)
        !user_mode |-> io_oe == '0) else $error("pins driven outside user mode");
    a_user_oe: assert property (@(posedge clock) disable iff (!nrst)
        user_mode |-> io_oe == '1 && !reg_reset) else $error("user mode without pins");
    a_user_after_init: assert property (@(posedge clock) disable iff (!nrst)
        $rose(user_mode) |-> $past(init_active)) else $error("user mode without init");
    a_init_after_load: assert property (@(posedge clock) disable iff (!nrst)
        $rose(init_active) |-> $past(state) == SCM_LOAD) else $error("init without load");
    a_reconf_exit: assert property (@(posedge clock) disable iff (!nrst)
        user_mode && reconf_req |=> ##1 !user_mode && io_oe == '0) else $error("reconfig ignored");
    a_chain_out: assert property (@(posedge clock) disable iff (!nrst)
        !chain_config_enable_out_n |-> init_active || user_mode) else $error("enable out early");
    a_load_gated: assert property (@(posedge clock) disable iff (!nrst)
        cfg_ready |-> $past(chain_en)) else $error("load without chain enable");
    a_scheme_ok: assert property (@(posedge clock) disable iff (!nrst)
        state == SCM_LOAD |-> scheme != 2'h3) else $error("bad scheme in load");
    a_rc_bound: assert property (@(posedge clock) disable iff (!nrst)
        rc_active |-> rc_cnt < 32'(RECONF_LIMIT)) else $error("reconfig count past limit");
    a_init_len: assert property (@(posedge clock) disable iff (!nrst)
        $rose(init_active) && INIT_CYCLES > 1 && !reconf_req |-> s_init_run)
        else $error("init too short");
    a_boot_sequence: assert property (@(posedge clock) disable iff (!nrst)
        $rose(user_mode) |-> !chain_config_enable_out_n) else $error("user without enable out");
endmodule

// [tb/scm_cfg_source.sv]
`timescale 1ns/1ps
module scm_cfg_source #(
    parameter int WIDTH = 8,
    parameter int WORDS = 8
) (
    input wire logic clock,
    input wire logic start,
    input wire logic slow,
    output logic cfg_valid,
    input wire logic cfg_ready,
    output logic [WIDTH-1:0] cfg_data,
    output logic done
);
    int idx;
    int gap;
    logic taken;
    initial
    begin
        cfg_valid = 1'h0;
        cfg_data = '0;
        done = 1'h0;
        idx = 0;
        gap = 0;
        taken = 1'h0;
    end
    always @(posedge clock) taken <= cfg_valid & cfg_ready;
    // Released data shows the inverse of the last value so stale words never look valid.
    always @(negedge clock)
    begin
        if (!start)
        begin
            idx = 0;
            done = 1'h0;
            cfg_valid = 1'h0;
            cfg_data = ~cfg_data;
        end
        else
        begin
            if (taken)
            begin
                idx++;
                gap = slow ? 2 : 0;
            end
            if (idx >= WORDS)
            begin
                done = 1'h1;
                cfg_valid = 1'h0;
                cfg_data = ~cfg_data;
            end
            else if (gap > 0)
            begin
                gap--;
                cfg_valid = 1'h0;
                cfg_data = ~cfg_data;
            end
            else
            begin
                cfg_valid = 1'h1;
                cfg_data = WIDTH'(idx * 29 + 90);
            end
        end
    end
endmodule

// [tb/test_sram_config_mode_control.sv]
`timescale 1ns/1ps
module test_sram_config_mode_control;
    import scm_pkg::*;
    localparam int WORDS = 8;
    localparam int LIMIT = 200;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic [1:0] scheme_sel = 2'h0;
    logic reconfig_n = 1'h1;
    logic en_in_n = 1'h1;
    logic start = 1'h0;
    logic slow = 1'h0;
    logic cfg_valid, cfg_ready, done, en_out_n, user_mode, init_active, reg_reset, scheme_error, reconf_timeout;
    logic [7:0] cfg_data, io_oe, cfg_checksum, sum;
    int failures = 0;
    int checked = 0;
    int n;
    always #25 clock = ~clock;
    scm_top #(.CFG_WORDS(WORDS), .INIT_CYCLES(4), .RECONF_LIMIT(LIMIT)) u_scm_top (.clock(clock), .nrst(nrst),
        .scheme_sel(scheme_sel), .reconfig_n(reconfig_n), .chain_config_enable_in_n(en_in_n),
        .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
        .chain_config_enable_out_n(en_out_n), .user_mode(user_mode), .init_active(init_active),
        .reg_reset(reg_reset), .scheme_error(scheme_error), .reconf_timeout(reconf_timeout),
        .io_oe(io_oe), .cfg_checksum(cfg_checksum));
    scm_cfg_source #(.WIDTH(8), .WORDS(WORDS)) u_scm_cfg_source (.clock(clock), .start(start), .slow(slow),
        .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data), .done(done));
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Waits at falling edges for init_active (0), user_mode (1) or command mode (2).
    task automatic wait_sig(input int sel, input int lim, output int cycles);
        logic hit;
        cycles = 0;
        hit = 1'h0;
        while (!hit)
        begin
            @(negedge clock);
            cycles++;
            hit = sel == 0 ? init_active === 1'h1 : sel == 1 ? user_mode === 1'h1 : user_mode === 1'h0;
            if (!hit && cycles >= lim)
            begin
                failures++;
                $display("FAIL %0t wait %0d timed out", $time, sel);
                complete_run();
            end
        end
    endtask
    task automatic test_power_up();
        check(io_oe, 8'h00, "pins driven before load");
        check({7'h0, user_mode}, 8'h00, "user mode before load");
        start = 1'h1;
        repeat (10) @(negedge clock);
        check({7'h0, cfg_ready}, 8'h00, "ready while chain disabled");
        check({7'h0, en_out_n}, 8'h01, "enable out before load");
        en_in_n = 1'h0;
        wait_sig(0, 100, n);
        sum = 8'h00;
        for (int i = 0; i < WORDS; i++)
            sum ^= 8'(i * 29 + 90);
        check(cfg_checksum, sum, "checksum");
        check({7'h0, en_out_n}, 8'h00, "enable out after load");
        check(io_oe, 8'h00, "pins driven in init");
        check({6'h0, user_mode, reg_reset}, 8'h01, "init mode");
        wait_sig(1, 20, n);
        check(io_oe, 8'hFF, "pins in user mode");
        check({6'h0, reg_reset, init_active}, 8'h00, "reset in user mode");
        $display("test_power_up done");
    endtask
    task automatic test_bad_scheme();
        start = 1'h0;
        reconfig_n = 1'h0;
        wait_sig(2, 10, n);
        scheme_sel = 2'h3;
        reconfig_n = 1'h1;
        repeat (10) @(negedge clock);
        check({6'h0, scheme_error, cfg_ready}, 8'h02, "invalid scheme");
        check(io_oe, 8'h00, "pins with invalid scheme");
        $display("test_bad_scheme done");
    endtask
    task automatic test_reload(input logic [1:0] s, input logic sl);
        int t;
        start = 1'h0;
        slow = sl;
        reconfig_n = 1'h0;
        wait_sig(2, 10, t);
        check(io_oe, 8'h00, "pins after force");
        check({7'h0, reg_reset}, 8'h01, "reset after force");
        scheme_sel = s;
        @(negedge clock);
        reconfig_n = 1'h1;
        start = 1'h1;
        wait_sig(1, LIMIT, n);
        check({7'h0, (t + n + 1) < LIMIT}, 8'h01, "reconfiguration too long");
        check({6'h0, reconf_timeout, scheme_error}, 8'h00, "timeout or error flag");
        check(io_oe, 8'hFF, "pins after reload");
        check({7'h0, done}, 8'h01, "all words taken");
        $display("test_reload scheme %0d done", s);
    endtask
    // Holds the chain enable off after a forced reconfiguration so the limit runs out.
    task automatic test_timeout();
        start = 1'h0;
        reconfig_n = 1'h0;
        wait_sig(2, 10, n);
        en_in_n = 1'h1;
        @(negedge clock);
        reconfig_n = 1'h1;
        repeat (LIMIT + 10) @(negedge clock);
        check({6'h0, reconf_timeout, cfg_ready}, 8'h02, "timeout flag");
        check({7'h0, en_out_n}, 8'h01, "enable out while chain disabled");
        check(io_oe, 8'h00, "pins while waiting for enable");
        en_in_n = 1'h0;
        start = 1'h1;
        wait_sig(1, 100, n);
        check({7'h0, reconf_timeout}, 8'h01, "timeout flag kept");
        check(io_oe, 8'hFF, "pins after late load");
        $display("test_timeout done");
    endtask
    initial
    begin
        repeat (3) @(negedge clock);
        nrst = 1'h1;
        test_power_up();
        test_bad_scheme();
        test_reload(2'h1, 1'h1);
        test_reload(2'h2, 1'h0);
        test_timeout();
        test_reload(2'h0, 1'h1);
        complete_run();
    end
endmodule
